// file: common/fault_pkg.sv
// Shared constants and carrier types of the axis and spindle fault monitor.
// Assumes one 25 MHz clock; every slower rate is derived from it.
package fault_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Timing.
   localparam int CLK_HZ = 25_000_000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES = CLK_HZ / 1_000_000 * TICK_US;
   localparam int SPIN_TO_MS = 3000;
   localparam int RES_TO_MS = 10;
   localparam int PRE_TO_MS = 3000;

   ////////////////////////////////////////////////////////////////////////
   // Limits and reset values.
   localparam logic [15:0] ENC_LINES = 16'h0400;
   localparam logic [15:0] PRE_MIN_DEF = 16'h0040;
   localparam logic [11:0] RES_MAX_DEF = 12'h0FA;
   localparam logic [15:0] SCALE_MIN_DEF = 16'h0000;
   localparam logic [15:0] SCALE_MAX_DEF = 16'hFFF0;
   localparam int STACK_DEPTH = 16;

   ////////////////////////////////////////////////////////////////////////
   // Error codes.
   localparam logic [4:0] ERR_NO_FB = 5'h01;
   localparam logic [4:0] ERR_ENC_TAP = 5'h02;
   localparam logic [4:0] ERR_RUNAWAY = 5'h03;
   localparam logic [4:0] ERR_LINES = 5'h04;
   localparam logic [4:0] ERR_NO_INDEX = 5'h05;
   localparam logic [4:0] ERR_UNUSED_A = 5'h06;
   localparam logic [4:0] ERR_PRE_COUNT = 5'h07;
   localparam logic [4:0] ERR_MAGNET = 5'h08;
   localparam logic [4:0] ERR_INVERTER = 5'h09;
   localparam logic [4:0] ERR_SPIN_QUIET = 5'h0A;
   localparam logic [4:0] ERR_UNUSED_B = 5'h0B;
   localparam logic [4:0] ERR_MOVE_COUNT = 5'h0C;
   localparam logic [4:0] ERR_NO_INIT = 5'h0E;
   localparam logic [4:0] ERR_PRE_TIME = 5'h0F;
   localparam logic [4:0] ERR_RES_TIME = 5'h10;
   localparam logic [4:0] ERR_RES_COUNT = 5'h11;
   localparam logic [4:0] ERR_AMP = 5'h12;
   localparam logic [4:0] ERR_OVERFLOW = 5'h13;
   localparam logic [4:0] ERR_CHECKSUM = 5'h14;
   localparam logic [4:0] ERR_SPURIOUS = 5'h15;
   localparam logic [4:0] ERR_SCALE = 5'h16;
   localparam logic [4:0] ERR_OVERLOAD = 5'h17;

   ////////////////////////////////////////////////////////////////////////
   // Carrier types.
   typedef enum logic [2:0] {
      OP_INIT0, OP_INIT1, OP_STEP, OP_DATA, OP_CHECK, OP_END
   } cmd_op_type;

   typedef struct packed {
      logic [2:0] op;
      logic [15:0] data;
   } cmd_type;

   typedef struct packed {
      logic enc_edge;
      logic enc_index;
      logic res_pulse;
      logic magnet;
      logic motion;
      logic dir_cmd;
      logic dir_act;
      logic inv_line;
      logic amp_line;
      logic scale_valid;
   } sense_type;

   typedef struct packed {
      logic powerup;
      logic cold_start;
      logic spindle_run;
      logic rigid_tap;
      logic precycle;
      logic enc1024;
      logic res_fb;
      logic [1:0] op_mode;
   } mode_type;

endpackage : fault_pkg

// file: rtl/timeout_timer.sv
// Millisecond watchdog: expires after more than LIMIT ticks with no kick.
// Assumes a one-cycle tick enable from a divider in the parent.
`timescale 1ns/1ps
module timeout_timer #(
   parameter int W = 12,
   parameter logic [W-1:0] LIMIT = '1
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_tick,
   input wire logic i_run,
   input wire logic i_kick,
   output logic o_expired
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic expired;
   } tmr_type;

   tmr_type st_reg;
   tmr_type st_next;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      if (!i_run || i_kick) begin
         st_next.cnt = '0;
         st_next.expired = 1'b0;
      end else if (i_tick && !st_reg.expired) begin
         if (st_reg.cnt == LIMIT) begin
            st_next.expired = 1'b1;
         end else begin
            st_next.cnt = st_reg.cnt + 1'b1;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_expired = st_reg.expired;

endmodule : timeout_timer

// file: rtl/cmd_stack.sv
// Command store: holds CPU commands in arrival order until serviced.
// Assumes DEPTH is a power of two; a push into a full store is lost unless a pop in the same cycle frees a slot.
`timescale 1ns/1ps
module cmd_stack #(
   parameter int W = 19,
   parameter int DEPTH = 16
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_push,
   input wire logic [W-1:0] i_data,
   input wire logic i_pop,
   output logic o_valid,
   output logic [W-1:0] o_data,
   output logic o_overflow
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW-1:0] wr;
      logic [AW-1:0] rd;
      logic [AW:0] cnt;
      logic [W-1:0] data;
      logic valid;
      logic overflow;
   } stk_type;

   stk_type st_reg;
   stk_type st_next;
   logic pop_ok;
   logic push_ok;

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_next = st_reg;
      st_next.valid = 1'b0;
      st_next.overflow = 1'b0;
      pop_ok = i_pop && (st_reg.cnt != '0);
      push_ok = i_push && (st_reg.cnt != (AW+1)'(DEPTH) || pop_ok);
      if (pop_ok) begin
         st_next.data = st_reg.mem[st_reg.rd];
         st_next.valid = 1'b1;
         st_next.rd = st_reg.rd + 1'b1;
      end
      if (push_ok) begin
         st_next.mem[st_reg.wr] = i_data;
         st_next.wr = st_reg.wr + 1'b1;
      end
      st_next.overflow = i_push && !push_ok;
      if (push_ok && !pop_ok) begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end else if (pop_ok && !push_ok) begin
         st_next.cnt = st_reg.cnt - 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_valid = st_reg.valid;
   assign o_data = st_reg.data;
   assign o_overflow = st_reg.overflow;

endmodule : cmd_stack

// file: rtl/axis_spindle_fault_monitor.sv
// Axis and spindle fault monitor: checks feedback, drive lines and the
// CPU command stream, and latches the first numbered error code.
// Assumes all inputs synchronous to i_clk; the CPU clears the latch.
//
// Contract
// (RQ1) Power-up ends with no feedback and no motion: code 1.
// (RQ2) Rigid tap, encoder quiet over 3 s: halt spindle, code 2.
// (RQ3) Power-up motion against command: halt axis, code 3.
// (RQ4) 1024-line encoder counting other than 1024 per turn: code 4; the code checks this only while powerup is set.
// (RQ5) Cold start ends without an index mark: code 5.
// (RQ6) Precycle ends with too few spindle counts: abort tap, code 7.
// (RQ7) Spindle runs, magnet quiet over 3 s: code 8.
// (RQ8) Drive inverter line high while running; line low: code 9.
// (RQ9) Spindle runs, encoder and magnet both quiet over 3 s: code 10.
// (RQ10) Move end pulse count differs from required count: code 12.
// (RQ11) CPU opens each move with init 0 or 1; else code 14.
// (RQ12) Precycle rotation or magnet quiet past timeout: code 15.
// (RQ13) Resolver zero-crossing pulse missing past 10 ms: code 16.
// (RQ14) Resolver count sampled at pulse above limit: code 17.
// (RQ15) Servo amplifier fault line not detected: code 18.
// (RQ16) Commands wait in a stack; overflow gives code 19.
// (RQ17) CPU sends checksum per move; mismatch gives code 20.
// (RQ18) Undefined command being serviced gives code 21.
// (RQ19) Scale reading outside limits gives code 22.
// (RQ20) Codes 6 and 11 are never reported.
// (RQ21) Every fault report carries its numeric code.
// (RQ22) Following error above overload factor: code 23 plus mode.
// (RQ23) First code is latched and held until the CPU clears it.
`timescale 1ns/1ps
module axis_spindle_fault_monitor
   import fault_pkg::*;
#(
   parameter int MS_CYCLES = TICK_CYCLES,
   parameter int DEPTH = STACK_DEPTH,
   parameter logic [15:0] PRE_MIN = PRE_MIN_DEF,
   parameter logic [11:0] RES_MAX = RES_MAX_DEF,
   parameter logic [15:0] SCALE_MIN = SCALE_MIN_DEF,
   parameter logic [15:0] SCALE_MAX = SCALE_MAX_DEF
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire sense_type i_sense,
   input wire mode_type i_mode,
   input wire logic [11:0] i_res_count,
   input wire logic [15:0] i_scale_val,
   input wire logic [15:0] i_follow_err,
   input wire logic [15:0] i_overload,
   input wire logic i_cmd_push,
   input wire cmd_type i_cmd,
   input wire logic i_service_en,
   input wire logic i_clear,
   output logic o_err_valid,
   output logic [4:0] o_err_code,
   output logic o_halt_axis,
   output logic o_halt_spindle,
   output logic o_abort_tap,
   output logic o_inv_line,
   output logic o_step
);

   localparam int NT = 5;
   localparam logic [NT-1:0][11:0] TO_LIM = {
      12'(RES_TO_MS), 12'(PRE_TO_MS), 12'(SPIN_TO_MS),
      12'(SPIN_TO_MS), 12'(SPIN_TO_MS)
   };

   typedef enum logic {MV_IDLE, MV_ACTIVE} move_type;

   typedef struct packed {
      logic [14:0] tick_cnt;
      logic tick;
      logic pu_d;
      logic cs_d;
      logic pre_d;
      logic fb_seen;
      logic motion_seen;
      logic idx_seen;
      logic lines_on;
      logic [15:0] lines;
      logic [15:0] pre_cnt;
      move_type mv;
      logic [15:0] pulse_cnt;
      logic [15:0] sum;
      logic err_valid;
      logic [4:0] err_code;
      logic halt_axis;
      logic halt_spindle;
      logic abort_tap;
      logic inv_line;
      logic step;
   } mon_type;

   mon_type st_reg;
   mon_type st_next;
   logic [31:0] hit;
   logic [4:0] first;
   logic [NT-1:0] t_run;
   logic [NT-1:0] t_kick;
   logic [NT-1:0] t_exp;
   logic cmd_valid;
   cmd_type cmd;
   logic overflow;

   ////////////////////////////////////////////////////////////////////////
   // Command store and watchdogs.
   cmd_stack #(
      .W($bits(cmd_type)),
      .DEPTH(DEPTH)
   ) u_stack (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_push(i_cmd_push),
      .i_data(i_cmd),
      .i_pop(i_service_en),
      .o_valid(cmd_valid),
      .o_data(cmd),
      .o_overflow(overflow)
   );

   assign t_run[0] = i_mode.rigid_tap | i_mode.precycle;
   assign t_kick[0] = i_sense.enc_edge;
   assign t_run[1] = i_mode.spindle_run;
   assign t_kick[1] = i_sense.magnet;
   assign t_run[2] = i_mode.spindle_run;
   assign t_kick[2] = i_sense.enc_edge | i_sense.magnet;
   assign t_run[3] = i_mode.precycle;
   assign t_kick[3] = i_sense.magnet;
   assign t_run[4] = i_mode.res_fb;
   assign t_kick[4] = i_sense.res_pulse;

   for (genvar g = 0; g < NT; g++) begin : g_tmr
      timeout_timer #(
         .W(12),
         .LIMIT(TO_LIM[g])
      ) u_tmr (
         .i_clk(i_clk),
         .i_rst(i_rst),
         .i_tick(st_reg.tick),
         .i_run(t_run[g]),
         .i_kick(t_kick[g]),
         .o_expired(t_exp[g])
      );
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks and error latch.
   always_comb begin
      st_next = st_reg;
      hit = '0;
      first = '0;
      st_next.step = 1'b0;
      st_next.tick = 1'b0;
      st_next.tick_cnt = st_reg.tick_cnt + 1'b1;
      if (st_reg.tick_cnt == 15'(MS_CYCLES - 1)) begin
         st_next.tick_cnt = '0;
         st_next.tick = 1'b1;
      end
      st_next.pu_d = i_mode.powerup;
      st_next.cs_d = i_mode.cold_start;
      st_next.pre_d = i_mode.precycle;
      st_next.fb_seen = i_mode.powerup &
         (st_reg.fb_seen | i_sense.enc_edge | i_sense.res_pulse);
      st_next.motion_seen = i_mode.powerup &
         (st_reg.motion_seen | i_sense.motion);
      hit[ERR_NO_FB] = st_reg.pu_d && !i_mode.powerup &&
         !st_reg.fb_seen && !st_reg.motion_seen; // RQ1
      hit[ERR_RUNAWAY] = i_mode.powerup && i_sense.motion &&
         (i_sense.dir_cmd != i_sense.dir_act); // RQ3
      if (!i_mode.powerup) begin
         st_next.lines_on = 1'b0;
         st_next.lines = '0;
      end else if (i_sense.enc_index) begin
         hit[ERR_LINES] = i_mode.enc1024 && st_reg.lines_on &&
            (st_reg.lines != ENC_LINES); // RQ4
         st_next.lines_on = 1'b1;
         st_next.lines = '0;
      end else if (i_sense.enc_edge) begin
         st_next.lines = st_reg.lines + 1'b1;
      end
      st_next.idx_seen = i_mode.cold_start &
         (st_reg.idx_seen | i_sense.enc_index);
      hit[ERR_NO_INDEX] = st_reg.cs_d && !i_mode.cold_start &&
         !st_reg.idx_seen; // RQ5
      st_next.pre_cnt = '0;
      if (i_mode.precycle) begin
         st_next.pre_cnt = st_reg.pre_cnt + 16'(i_sense.enc_edge);
      end
      hit[ERR_PRE_COUNT] = st_reg.pre_d && !i_mode.precycle &&
         (st_reg.pre_cnt < PRE_MIN); // RQ6
      hit[ERR_ENC_TAP] = t_exp[0] && !i_mode.precycle; // RQ2
      hit[ERR_MAGNET] = t_exp[1] && !t_exp[2]; // RQ7
      hit[ERR_INVERTER] = i_mode.spindle_run && !i_sense.inv_line; // RQ8
      hit[ERR_SPIN_QUIET] = t_exp[2]; // RQ9
      hit[ERR_PRE_TIME] = i_mode.precycle && (t_exp[0] || t_exp[3]); // RQ12
      hit[ERR_RES_TIME] = t_exp[4]; // RQ13
      hit[ERR_RES_COUNT] = i_sense.res_pulse &&
         (i_res_count > RES_MAX); // RQ14
      hit[ERR_AMP] = !i_sense.amp_line; // RQ15
      hit[ERR_OVERFLOW] = overflow; // RQ16
      hit[ERR_SCALE] = i_sense.scale_valid &&
         (i_scale_val < SCALE_MIN || i_scale_val > SCALE_MAX); // RQ19
      hit[ERR_OVERLOAD + 5'(i_mode.op_mode)] =
         i_follow_err > i_overload; // RQ22
      if (cmd_valid) begin
         unique case (cmd.op)
            OP_INIT0, OP_INIT1: begin
               st_next.mv = MV_ACTIVE;
               st_next.pulse_cnt = '0;
               st_next.sum = '0;
            end
            OP_STEP: begin
               hit[ERR_NO_INIT] = (st_reg.mv == MV_IDLE); // RQ11
               if (st_reg.mv == MV_ACTIVE) begin
                  st_next.pulse_cnt = st_reg.pulse_cnt + 1'b1;
                  st_next.step = 1'b1;
               end
            end
            OP_DATA: begin
               hit[ERR_NO_INIT] = (st_reg.mv == MV_IDLE); // RQ11
               st_next.sum = st_reg.sum + cmd.data;
            end
            OP_CHECK: begin
               hit[ERR_NO_INIT] = (st_reg.mv == MV_IDLE); // RQ11
               hit[ERR_CHECKSUM] = (st_reg.mv == MV_ACTIVE) &&
                  (st_reg.sum != cmd.data); // RQ17
            end
            OP_END: begin
               hit[ERR_NO_INIT] = (st_reg.mv == MV_IDLE); // RQ11
               hit[ERR_MOVE_COUNT] = (st_reg.mv == MV_ACTIVE) &&
                  (st_reg.pulse_cnt != cmd.data); // RQ10
               st_next.mv = MV_IDLE;
            end
            default: begin
               hit[ERR_SPURIOUS] = 1'b1; // RQ18
            end
         endcase
      end
      hit[ERR_UNUSED_A] = 1'b0; // RQ20
      hit[ERR_UNUSED_B] = 1'b0; // RQ20
      hit[0] = 1'b0;
      for (int i = 31; i > 0; i--) begin
         if (hit[i]) begin
            first = 5'(i);
         end
      end
      if (i_clear) begin
         st_next.err_valid = 1'b0;
         st_next.halt_axis = 1'b0;
         st_next.halt_spindle = 1'b0;
         st_next.abort_tap = 1'b0;
      end
      if (hit != '0 && (!st_reg.err_valid || i_clear)) begin
         st_next.err_valid = 1'b1; // RQ23
         st_next.err_code = first; // RQ21
      end
      if (hit[ERR_ENC_TAP]) begin
         st_next.halt_spindle = 1'b1; // RQ2
      end
      if (hit[ERR_RUNAWAY]) begin
         st_next.halt_axis = 1'b1; // RQ3
      end
      if (hit[ERR_PRE_COUNT]) begin
         st_next.abort_tap = 1'b1; // RQ6
      end
      st_next.inv_line = i_mode.spindle_run && !st_reg.halt_spindle; // RQ8
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign o_err_valid = st_reg.err_valid;
   assign o_err_code = st_reg.err_code;
   assign o_halt_axis = st_reg.halt_axis;
   assign o_halt_spindle = st_reg.halt_spindle;
   assign o_abort_tap = st_reg.abort_tap;
   assign o_inv_line = st_reg.inv_line;
   assign o_step = st_reg.step;

   ////////////////////////////////////////////////////////////////////////
   // Assertions.
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);

   hold_code_a: assert property ( // RQ23
      o_err_valid && !i_clear |=> o_err_valid && $stable(o_err_code))
      else $error("Latched error code changed without a clear.");
   no_reserved_a: assert property ( // RQ20
      o_err_valid |-> o_err_code != ERR_UNUSED_A &&
         o_err_code != ERR_UNUSED_B)
      else $error("Reserved error code reported.");
   amp_down_a: assert property ( // RQ15
      !i_sense.amp_line && !o_err_valid |=>
         o_err_valid && o_err_code <= ERR_AMP)
      else $error("Amplifier fault line loss not reported.");
   spin_halt_a: assert property ( // RQ2
      o_err_valid && o_err_code == ERR_ENC_TAP |-> o_halt_spindle)
      else $error("Encoder loss in tapping did not halt the spindle.");
   runaway_a: assert property ( // RQ3
      i_mode.powerup && i_sense.motion && !i_clear &&
      i_sense.dir_cmd != i_sense.dir_act |=> o_halt_axis)
      else $error("Runaway at power-up did not halt the axis.");
   tap_abort_a: assert property ( // RQ6
      o_err_valid && o_err_code == ERR_PRE_COUNT |-> o_abort_tap)
      else $error("Low precycle count did not abort the tap.");
   inv_drive_a: assert property ( // RQ8
      i_mode.spindle_run && !o_halt_spindle |=> o_inv_line)
      else $error("Inverter line not driven high while running.");
   res_count_a: assert property ( // RQ14
      i_sense.res_pulse && i_res_count > RES_MAX && !o_err_valid |=>
         o_err_valid && o_err_code <= ERR_RES_COUNT)
      else $error("Resolver count above limit not reported.");
   overflow_a: assert property ( // RQ16
      overflow && !o_err_valid |=> o_err_valid &&
         o_err_code <= ERR_OVERFLOW)
      else $error("Store overflow not reported.");
   inv_low_a: assert property ( // RQ8
      i_mode.spindle_run && !i_sense.inv_line && !o_err_valid |=>
         o_err_valid && o_err_code <= ERR_INVERTER)
      else $error("Inverter line low not reported.");
   inv_off_a: assert property ( // RQ8
      !i_mode.spindle_run |=> !o_inv_line)
      else $error("Inverter line driven with spindle off.");
   clear_drop_a: assert property ( // RQ23
      i_clear && hit == '0 |=> !o_err_valid && !o_halt_axis &&
         !o_halt_spindle && !o_abort_tap)
      else $error("Clear did not release latch and halts.");
   scale_err_a: assert property ( // RQ19
      i_sense.scale_valid && i_scale_val > SCALE_MAX && !o_err_valid |=>
         o_err_valid && o_err_code <= ERR_SCALE)
      else $error("Scale reading above limit not reported.");
   spurious_a: assert property ( // RQ18
      cmd_valid && cmd.op > 3'h5 && !o_err_valid |=>
         o_err_valid && o_err_code <= ERR_SPURIOUS)
      else $error("Undefined command not reported.");

   move_err_c: cover property (o_err_valid && o_err_code == ERR_MOVE_COUNT);
   step_c: cover property (o_step ##1 o_step);
   clear_c: cover property (o_err_valid ##1 !o_err_valid);
   spin_quiet_c: cover property (o_err_valid && o_err_code == ERR_SPIN_QUIET);
   overflow_c: cover property (o_err_valid && o_err_code == ERR_OVERFLOW);

endmodule : axis_spindle_fault_monitor

// file: verif/cpu_model.sv
// Main CPU model: sends move commands into the command store.
// Assumes the bench calls its tasks; pushes launch at the rising edge.
`timescale 1ns/1ps
module cpu_model
   import fault_pkg::*;
(
   input wire logic i_clk,
   output logic o_push,
   output cmd_type o_cmd
);
   initial begin
      o_push = 1'b0;
      o_cmd = '0;
   end

   ////////////////////////////////////////////////////////////////////////
   // One push a cycle; back to back calls keep o_push high.
   task put(input logic [2:0] op, input logic [15:0] data);
      @(posedge i_clk);
      o_push <= 1'b1;
      o_cmd <= '{op: op, data: data};
   endtask : put

   // Released command lines show the inverse of the last value.
   task idle();
      @(posedge i_clk);
      o_push <= 1'b0;
      o_cmd <= ~o_cmd;
   endtask : idle

   ////////////////////////////////////////////////////////////////////////
   // Whole move: init, two data words, steps, checksum, end count.
   task move(input int steps, input logic [15:0] count,
             input logic with_init, input logic bad_sum);
      logic [15:0] sum;
      sum = 16'h1234 + 16'hF00F;
      if (with_init) begin
         put(OP_INIT0, 16'h0000);
      end
      put(OP_DATA, 16'h1234);
      put(OP_DATA, 16'hF00F);
      repeat (steps) put(OP_STEP, 16'h0000);
      put(OP_CHECK, bad_sum ? sum + 16'h0001 : sum);
      put(OP_END, count);
      idle();
   endtask : move
endmodule : cpu_model

// file: verif/axis_spindle_fault_monitor_tb_top.sv
// Self-checking bench of the axis and spindle fault monitor.
// Assumes a 25 MHz clock and a 10-cycle millisecond tick.
`timescale 1ns/1ps
module axis_spindle_fault_monitor_tb_top;
   import fault_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   sense_type sense = '{amp_line: 1'b1, inv_line: 1'b1, default: 1'b0};
   mode_type mode = '0;
   logic [11:0] res_count = 12'h000;
   logic [15:0] scale_val = 16'h0000;
   logic [15:0] follow_err = 16'h0000;
   logic [15:0] overload = 16'h0100;
   logic service_en = 1'b1;
   logic i_clear = 1'b0;
   logic cmd_push;
   cmd_type cmd;
   logic o_err_valid, o_halt_axis, o_halt_spindle, o_abort_tap;
   logic o_inv_line, o_step;
   logic [4:0] o_err_code;
   int n_errors = 0;
   int comparisons = 0;
   int n_steps = 0;

   always #20 i_clk = ~i_clk;
   always @(negedge i_clk) if (o_step === 1'b1) n_steps++;

   cpu_model cpu (.i_clk(i_clk), .o_push(cmd_push), .o_cmd(cmd));

   axis_spindle_fault_monitor #(.MS_CYCLES(10)) dut (
      .i_clk(i_clk), .i_rst(i_rst), .i_sense(sense), .i_mode(mode),
      .i_res_count(res_count), .i_scale_val(scale_val),
      .i_follow_err(follow_err), .i_overload(overload),
      .i_cmd_push(cmd_push), .i_cmd(cmd), .i_service_en(service_en),
      .i_clear(i_clear), .o_err_valid(o_err_valid),
      .o_err_code(o_err_code), .o_halt_axis(o_halt_axis),
      .o_halt_spindle(o_halt_spindle), .o_abort_tap(o_abort_tap),
      .o_inv_line(o_inv_line), .o_step(o_step));

   ////////////////////////////////////////////////////////////////////////
   // Shared helpers.
   task check(input string name, input logic [15:0] seen, exp);
      comparisons++;
      if (seen !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask : check

   task tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask : tick

   task wait_err(input logic [4:0] code, input int n);
      int k;
      k = 0;
      @(negedge i_clk);
      while (o_err_valid !== 1'b1 && k < n) begin
         @(negedge i_clk);
         k++;
      end
      check("err_valid", o_err_valid, 16'h0001);
      check("err_code", o_err_code, code);
   endtask : wait_err

   task quiet(input int n);
      repeat (n) @(negedge i_clk);
      check("no_err", o_err_valid, 16'h0000);
   endtask : quiet

   task pulse_clear();
      @(posedge i_clk);
      i_clear <= 1'b1;
      @(posedge i_clk);
      i_clear <= 1'b0;
   endtask : pulse_clear

   task clr();
      pulse_clear();
      @(negedge i_clk);
      check("cleared", o_err_valid, 16'h0000);
   endtask : clr

   ////////////////////////////////////////////////////////////////////////
   // Command path scenarios.
   task t_moves();
      cpu.move(3, 16'h0003, 1'b1, 1'b0);
      quiet(8);
      check("steps", n_steps, 16'h0003);
      cpu.move(2, 16'h0003, 1'b1, 1'b0);
      wait_err(ERR_MOVE_COUNT, 10);
      clr();
      cpu.move(1, 16'h0001, 1'b0, 1'b0);
      wait_err(ERR_NO_INIT, 10);
      tick(3);
      clr();
      cpu.move(1, 16'h0001, 1'b1, 1'b1);
      wait_err(ERR_CHECKSUM, 10);
      clr();
      cpu.put(3'd6, 16'h0000);
      cpu.idle();
      wait_err(ERR_SPURIOUS, 10);
      clr();
   endtask : t_moves

   task t_overflow();
      service_en <= 1'b0;
      repeat (16) cpu.put(OP_INIT1, 16'h0000);
      cpu.idle();
      quiet(3);
      cpu.put(OP_INIT1, 16'h0000);
      cpu.idle();
      wait_err(ERR_OVERFLOW, 5);
      service_en <= 1'b1;
      tick(20);
      clr();
   endtask : t_overflow

   ////////////////////////////////////////////////////////////////////////
   // Sensor path scenarios.
   task t_amp_scale();
      sense.amp_line <= 1'b0;
      wait_err(ERR_AMP, 3);
      @(posedge i_clk);
      scale_val <= 16'hFFF1;
      sense.scale_valid <= 1'b1;
      sense.amp_line <= 1'b1;
      @(posedge i_clk);
      sense.scale_valid <= 1'b0;
      tick(3);
      wait_err(ERR_AMP, 0);
      clr();
      @(posedge i_clk);
      sense.scale_valid <= 1'b1;
      @(posedge i_clk);
      sense.scale_valid <= 1'b0;
      wait_err(ERR_SCALE, 3);
      clr();
   endtask : t_amp_scale

   task res_pulse(input logic [11:0] c);
      @(posedge i_clk);
      res_count <= c;
      sense.res_pulse <= 1'b1;
      @(posedge i_clk);
      sense.res_pulse <= 1'b0;
   endtask : res_pulse

   task t_resolver();
      mode.res_fb <= 1'b1;
      res_pulse(RES_MAX_DEF);
      quiet(80);
      wait_err(ERR_RES_TIME, 60);
      res_pulse(RES_MAX_DEF);
      clr();
      res_pulse(RES_MAX_DEF + 12'h001);
      wait_err(ERR_RES_COUNT, 3);
      mode.res_fb <= 1'b0;
      clr();
   endtask : t_resolver

   task t_windows();
      mode.powerup <= 1'b1;
      tick(4);
      mode.powerup <= 1'b0;
      wait_err(ERR_NO_FB, 3);
      clr();
      mode.powerup <= 1'b1;
      sense.motion <= 1'b1;
      sense.dir_cmd <= 1'b1;
      wait_err(ERR_RUNAWAY, 3);
      check("halt_axis", o_halt_axis, 16'h0001);
      mode.powerup <= 1'b0;
      sense.motion <= 1'b0;
      sense.dir_cmd <= 1'b0;
      clr();
      mode.cold_start <= 1'b1;
      tick(4);
      mode.cold_start <= 1'b0;
      wait_err(ERR_NO_INDEX, 3);
      clr();
      mode.powerup <= 1'b1;
      mode.enc1024 <= 1'b1;
      repeat (2) begin
         @(posedge i_clk) sense.enc_index <= 1'b1;
         @(posedge i_clk) sense.enc_index <= 1'b0;
         sense.enc_edge <= 1'b1;
         tick(3);
         sense.enc_edge <= 1'b0;
      end
      wait_err(ERR_LINES, 3);
      mode <= '0;
      clr();
      mode.precycle <= 1'b1;
      repeat (10) begin
         @(posedge i_clk) sense.enc_edge <= 1'b1;
         @(posedge i_clk) sense.enc_edge <= 1'b0;
      end
      mode.precycle <= 1'b0;
      wait_err(ERR_PRE_COUNT, 3);
      check("abort_tap", o_abort_tap, 16'h0001);
      clr();
   endtask : t_windows

   task t_overload();
      for (int m = 0; m < 4; m++) begin
         @(posedge i_clk);
         mode.op_mode <= m[1:0];
         follow_err <= 16'h0101;
         wait_err(ERR_OVERLOAD + m[4:0], 3);
         follow_err <= 16'h0000;
         clr();
      end
      mode.op_mode <= 2'd0;
   endtask : t_overload

   task t_spindle();
      mode.spindle_run <= 1'b1;
      quiet(3);
      check("inv_drive", o_inv_line, 16'h0001);
      @(posedge i_clk) sense.inv_line <= 1'b0;
      wait_err(ERR_INVERTER, 3);
      sense.inv_line <= 1'b1;
      clr();
      repeat (14500) begin
         @(posedge i_clk) sense.enc_edge <= 1'b1;
         @(posedge i_clk) sense.enc_edge <= 1'b0;
      end
      quiet(1);
      wait_err(ERR_MAGNET, 2000);
      mode.spindle_run <= 1'b0;
      clr();
      mode <= '{spindle_run: 1'b1, rigid_tap: 1'b1, precycle: 1'b1,
         default: '0};
      quiet(29000);
      wait_err(ERR_SPIN_QUIET, 2000);
      mode.spindle_run <= 1'b0;
      pulse_clear();
      wait_err(ERR_PRE_TIME, 3);
      mode.precycle <= 1'b0;
      pulse_clear();
      wait_err(ERR_ENC_TAP, 3);
      check("halt_spindle", o_halt_spindle, 16'h0001);
      mode <= '0;
      clr();
   endtask : t_spindle

   ////////////////////////////////////////////////////////////////////////
   // Verdict and run control.
   task conclude();
      $display("comparisons %0d errors %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude

   initial begin
      #3_200_000;
      n_errors++;
      conclude();
   end

   initial begin
      tick(2);
      i_rst <= 1'b0;
      tick(2);
      t_moves();
      t_overflow();
      t_amp_scale();
      t_resolver();
      t_windows();
      t_overload();
      t_spindle();
      conclude();
   end
endmodule : axis_spindle_fault_monitor_tb_top
